// ---- rtl/evq_pkg.sv ----
// Constants, register map and types shared by the event queue interrupt unit
// Summary of operation
// - A rising edge on a fast input sets that input's pulse capture flag.
// - All eight pulse capture flags clear when the user program starts.
// - Capture flag freezes after the first scan if input is shared with counting.
// - An event becomes a request only with its own enable and global enable on.
// - Each enabled event number is pushed into an eight entry FIFO queue.
// - A non-empty queue suspends the main program so requests get served.
// - The head event number is read and its linked handler is started.
// - A finished handler pops the head; main program resumes once empty.
// - One request is served at a time; new events queue, never preempt.
// - A full queue masks new events until it drains and main resumes.
// - A request without linked handler is still dequeued, with empty response.
// - Three periodic timers raise events 26 to 28 at their millisecond intervals.
// - Changing a timer enable leaves already queued timer requests untouched.
// - A re-enabled timer restarts its interval count from zero.
// - Edge events 0-7 rise, 10-17 fall; one enable per input covers both.
// - External edges are served up to one thousand per second; faster may drop.
// - Counter events 20-25, 40 and 41 share one counter event enable.
// - Serial port events 30 to 37 each have their own enable.
// - Pulse train done events 18, 19 and 42 to 47 each have own enable.
package evq_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int EVQ_DEPTH = 8;
   localparam int EVQ_AW = 3;
   localparam int EVQ_EW = 6;
   localparam int EVQ_NEVT = 64;
   localparam int EVQ_NTMR = 3;
   localparam logic [3:0] EVQ_FULL_COUNT = 4'h8;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int INTERVAL_UNIT_NS = 1000000;
   localparam int CYCLES_PER_MS = INTERVAL_UNIT_NS / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Event numbers
   // ----------------------------------------------------------------
   localparam int EV_RISE_BASE = 0;
   localparam int EV_FALL_BASE = 10;
   localparam int EV_PULSE_LO_BASE = 18;
   localparam int EV_CNT_LO_BASE = 20;
   localparam int EV_TIMER_BASE = 26;
   localparam int EV_SERIAL_BASE = 30;
   localparam int EV_CNT_HI_BASE = 40;
   localparam int EV_PULSE_HI_BASE = 42;

   // ----------------------------------------------------------------
   // Register word indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_ENABLES = 4'h1;
   localparam logic [3:0] REG_TIMER_EN = 4'h2;
   localparam logic [3:0] REG_TIMER0_IVL = 4'h3;
   localparam logic [3:0] REG_TIMER1_IVL = 4'h4;
   localparam logic [3:0] REG_TIMER2_IVL = 4'h5;
   localparam logic [3:0] REG_SHARED = 4'h6;
   localparam logic [3:0] REG_CAPTURE = 4'h7;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam logic [3:0] REG_LINK_LO = 4'h9;
   localparam logic [3:0] REG_LINK_HI = 4'hA;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_GLOBAL_BIT = 0;
   localparam int CTRL_COUNTER_BIT = 1;
   localparam int EN_EDGE_LSB = 0;
   localparam int EN_SERIAL_LSB = 8;
   localparam int EN_PULSE_LSB = 16;
   localparam int ST_COUNT_LSB = 0;
   localparam int ST_MASK_BIT = 4;
   localparam int ST_BUSY_BIT = 5;
   localparam int ST_SUSP_BIT = 6;
   localparam int ST_LOST_BIT = 7;
   localparam int ST_HEAD_LSB = 8;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam logic [23:0] ENABLES_RST = 24'h000000;
   localparam logic [2:0] TIMER_EN_RST = 3'h0;
   localparam logic [15:0] INTERVAL_RST = 16'h0000;
   localparam logic [7:0] SHARED_RST = 8'h00;
   localparam logic [63:0] LINK_RST = 64'h0000000000000000;

   typedef enum logic [1:0] {
      EVQ_IDLE = 2'b00,
      EVQ_FETCH = 2'b01,
      EVQ_DISPATCH = 2'b10,
      EVQ_RUN = 2'b11
   } evq_state_t;

endpackage

// ---- rtl/evq_queue_mem.sv ----
// Request queue storage: eight event numbers, registered read port
`timescale 1ns/1ps
module evq_queue_mem (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic wr_en,
   input wire logic [evq_pkg::EVQ_AW-1:0] wr_addr,
   input wire logic [evq_pkg::EVQ_EW-1:0] wr_data,
   input wire logic [evq_pkg::EVQ_AW-1:0] rd_addr,
   output logic [evq_pkg::EVQ_EW-1:0] rd_data
);

   typedef struct packed {
      logic [evq_pkg::EVQ_DEPTH-1:0][evq_pkg::EVQ_EW-1:0] mem;
      logic [evq_pkg::EVQ_EW-1:0] rdata;
   } evq_mem_s_t;

   evq_mem_s_t st_reg;
   evq_mem_s_t st_next;

   always_comb begin
      st_next = st_reg;
      // Read sees the old word on a same-cycle write to the same slot
      st_next.rdata = st_reg.mem[rd_addr];
      if (wr_en) begin
         st_next.mem[wr_addr] = wr_data;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rd_data = st_reg.rdata;

endmodule

// ---- rtl/evq_timer.sv ----
// Periodic millisecond event source
`timescale 1ns/1ps
module evq_timer #(
   parameter int CYC_PER_MS = evq_pkg::CYCLES_PER_MS
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic enable,
   input wire logic [15:0] interval,
   output logic fire
);

   typedef struct packed {
      logic [31:0] presc;
      logic [15:0] ms;
      logic fire;
   } evq_tmr_s_t;

   evq_tmr_s_t st_reg;
   evq_tmr_s_t st_next;

   always_comb begin
      st_next = st_reg;
      st_next.fire = 1'b0;
      if (!enable) begin
         // Held at zero while off, so a re-enable starts a fresh interval
         st_next.presc = '0;
         st_next.ms = '0;
      end else if (st_reg.presc == 32'(CYC_PER_MS - 1)) begin
         st_next.presc = '0;
         // Zero interval never fires
         if ((interval != 16'h0000) && (16'(st_reg.ms + 16'h0001) >= interval)) begin
            st_next.ms = '0;
            st_next.fire = 1'b1;
         end else begin
            st_next.ms = 16'(st_reg.ms + 16'h0001);
         end
      end else begin
         st_next.presc = 32'(st_reg.presc + 32'h00000001);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign fire = st_reg.fire;

endmodule

// ---- rtl/evq_top.sv ----
// Event queue interrupt unit: edge capture, event gating, request FIFO, dispatch
`timescale 1ns/1ps
module evq_top #(
   parameter int CYCLES_PER_MS = evq_pkg::CYCLES_PER_MS
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [7:0] fast_inputs,
   input wire logic [7:0] counter_events,
   input wire logic [7:0] serial_events,
   input wire logic [7:0] pulse_done_events,
   input wire logic program_start,
   input wire logic scan_end,
   input wire logic handler_done,
   output logic handler_start,
   output logic [5:0] handler_event,
   output logic main_suspend,
   output logic [7:0] pulse_capture_flags
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] in_prev;
      logic [7:0] capture;
      logic first_scan_done;
      logic [1:0] ctrl;
      logic [23:0] enables;
      logic [2:0] timer_en;
      logic [2:0][15:0] interval;
      logic [7:0] shared;
      logic [63:0] link;
      logic [63:0] pending;
      logic [2:0] wr_ptr;
      logic [2:0] rd_ptr;
      logic [3:0] count;
      logic masked;
      logic lost;
      evq_pkg::evq_state_t state;
      logic [5:0] head;
      logic start;
      logic [5:0] evt_out;
      logic suspend;
      logic waitreq;
      logic [31:0] rdata;
   } evq_top_s_t;

   localparam evq_top_s_t ST_RST = '{
      in_prev: 8'h00,
      capture: 8'h00,
      first_scan_done: 1'b0,
      ctrl: evq_pkg::CTRL_RST,
      enables: evq_pkg::ENABLES_RST,
      timer_en: evq_pkg::TIMER_EN_RST,
      interval: {3{evq_pkg::INTERVAL_RST}},
      shared: evq_pkg::SHARED_RST,
      link: evq_pkg::LINK_RST,
      pending: 64'h0000000000000000,
      wr_ptr: 3'h0,
      rd_ptr: 3'h0,
      count: 4'h0,
      masked: 1'b0,
      lost: 1'b0,
      state: evq_pkg::EVQ_IDLE,
      head: 6'h00,
      start: 1'b0,
      evt_out: 6'h00,
      suspend: 1'b0,
      waitreq: 1'b1,
      rdata: 32'h00000000
   };

   evq_top_s_t st_reg;
   evq_top_s_t st_next;

   logic [2:0] tmr_fire;
   logic [5:0] q_rdata;
   logic push;
   logic pop;
   logic [5:0] sel;
   logic [63:0] evt;
   logic [7:0] rise;
   logic [7:0] fall;
   logic rd_take;
   logic wr_take;
   logic [31:0] status;

   // ----------------------------------------------------------------
   // Timers and queue storage
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < evq_pkg::EVQ_NTMR; gi++) begin : g_tmr
         evq_timer #(
            .CYC_PER_MS(CYCLES_PER_MS)
         ) u_timer (
            .clk(clk),
            .arst_n(arst_n),
            .enable(st_reg.timer_en[gi]),
            .interval(st_reg.interval[gi]),
            .fire(tmr_fire[gi])
         );
      end
   endgenerate

   evq_queue_mem u_mem (
      .clk(clk),
      .arst_n(arst_n),
      .wr_en(push),
      .wr_addr(st_reg.wr_ptr),
      .wr_data(sel),
      .rd_addr(st_reg.rd_ptr),
      .rd_data(q_rdata)
   );

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      return (old & ~m) | (wd & m);
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.start = 1'b0;
      evt = '0;
      sel = '0;
      push = 1'b0;
      pop = 1'b0;

      // Bus: waitrequest drops for exactly one cycle per request
      rd_take = avs_read & st_reg.waitreq;
      wr_take = avs_write & ~st_reg.waitreq;
      st_next.waitreq = ~((avs_read | avs_write) & st_reg.waitreq);

      // Edge detection and pulse capture
      rise = fast_inputs & ~st_reg.in_prev;
      fall = ~fast_inputs & st_reg.in_prev;
      st_next.in_prev = fast_inputs;
      for (int i = 0; i < 8; i++) begin
         if (st_reg.shared[i] && st_reg.first_scan_done) begin
            // Frozen input keeps its flag but still obeys the start clear
            st_next.capture[i] = st_reg.capture[i] & ~program_start;
         end else begin
            // Set beats the program-start clear in the same cycle
            st_next.capture[i] = (st_reg.capture[i] & ~program_start) | rise[i];
         end
      end
      if (program_start) begin
         st_next.first_scan_done = 1'b0;
      end else if (scan_end) begin
         st_next.first_scan_done = 1'b1;
      end

      // Event vector; counter events share one ctrl enable, other sources have their own
      for (int i = 0; i < 8; i++) begin
         evt[evq_pkg::EV_RISE_BASE + i] = rise[i] & st_reg.enables[evq_pkg::EN_EDGE_LSB + i];
         evt[evq_pkg::EV_FALL_BASE + i] = fall[i] & st_reg.enables[evq_pkg::EN_EDGE_LSB + i];
         evt[evq_pkg::EV_SERIAL_BASE + i] = serial_events[i]
            & st_reg.enables[evq_pkg::EN_SERIAL_LSB + i];
         if (i < 2) begin
            evt[evq_pkg::EV_PULSE_LO_BASE + i] = pulse_done_events[i]
               & st_reg.enables[evq_pkg::EN_PULSE_LSB + i];
         end else begin
            evt[evq_pkg::EV_PULSE_HI_BASE + i - 2] = pulse_done_events[i]
               & st_reg.enables[evq_pkg::EN_PULSE_LSB + i];
         end
         if (i < 6) begin
            evt[evq_pkg::EV_CNT_LO_BASE + i] = counter_events[i]
               & st_reg.ctrl[evq_pkg::CTRL_COUNTER_BIT];
         end else begin
            evt[evq_pkg::EV_CNT_HI_BASE + i - 6] = counter_events[i]
               & st_reg.ctrl[evq_pkg::CTRL_COUNTER_BIT];
         end
      end
      for (int t = 0; t < evq_pkg::EVQ_NTMR; t++) begin
         evt[evq_pkg::EV_TIMER_BASE + t] = tmr_fire[t] & st_reg.timer_en[t];
      end
      if (!st_reg.ctrl[evq_pkg::CTRL_GLOBAL_BIT]) begin
         evt = '0;
      end

      // Lowest pending number goes first
      for (int k = evq_pkg::EVQ_NEVT - 1; k >= 0; k--) begin
         if (st_reg.pending[k]) begin
            sel = 6'(k);
         end
      end
      push = (st_reg.pending != 64'h0000000000000000) && !st_reg.masked
         && (st_reg.count != evq_pkg::EVQ_FULL_COUNT);

      // Dispatch: one request in service at a time
      case (st_reg.state)
         evq_pkg::EVQ_IDLE: begin
            if (st_reg.count != 4'h0) begin
               st_next.state = evq_pkg::EVQ_FETCH;
            end
         end
         evq_pkg::EVQ_FETCH: begin
            st_next.head = q_rdata;
            st_next.state = evq_pkg::EVQ_DISPATCH;
         end
         evq_pkg::EVQ_DISPATCH: begin
            if (st_reg.link[st_reg.head]) begin
               st_next.start = 1'b1;
               st_next.evt_out = st_reg.head;
               st_next.state = evq_pkg::EVQ_RUN;
            end else begin
               pop = 1'b1;
               st_next.state = evq_pkg::EVQ_IDLE;
            end
         end
         evq_pkg::EVQ_RUN: begin
            // New events only queue up here, nothing preempts the handler
            if (handler_done) begin
               pop = 1'b1;
               st_next.state = evq_pkg::EVQ_IDLE;
            end
         end
         default: begin
            st_next.state = evq_pkg::EVQ_IDLE;
         end
      endcase

      // Pending set: a repeat of a still-pending event merges with it, which
      // is where edges faster than service get lost
      if (push) begin
         st_next.pending[sel] = 1'b0;
         st_next.wr_ptr = 3'(st_reg.wr_ptr + 3'h1);
      end
      if (!st_reg.masked) begin
         st_next.pending = st_next.pending | evt;
      end else if ((evt | st_reg.pending) != '0) begin
         st_next.pending = '0;
         st_next.lost = 1'b1;
      end
      if (pop) begin
         st_next.rd_ptr = 3'(st_reg.rd_ptr + 3'h1);
      end
      st_next.count = 4'(st_reg.count + {3'h0, push} - {3'h0, pop});

      // Mask holds until empty and the main program is running again
      if (st_next.count == evq_pkg::EVQ_FULL_COUNT) begin
         st_next.masked = 1'b1;
      end else if ((st_reg.count == 4'h0) && (st_reg.state == evq_pkg::EVQ_IDLE)
                   && !st_reg.suspend) begin
         st_next.masked = 1'b0;
      end
      st_next.suspend = (st_next.count != 4'h0)
         || (st_next.state != evq_pkg::EVQ_IDLE);

      // Status word
      status = '0;
      status[evq_pkg::ST_COUNT_LSB +: 4] = st_reg.count;
      status[evq_pkg::ST_MASK_BIT] = st_reg.masked;
      status[evq_pkg::ST_BUSY_BIT] = (st_reg.state == evq_pkg::EVQ_RUN);
      status[evq_pkg::ST_SUSP_BIT] = st_reg.suspend;
      status[evq_pkg::ST_LOST_BIT] = st_reg.lost;
      status[evq_pkg::ST_HEAD_LSB +: 6] = st_reg.head;

      // Register read; unmapped words read as zero
      if (rd_take) begin
         case (avs_address)
            evq_pkg::REG_CTRL: st_next.rdata = {30'h0, st_reg.ctrl};
            evq_pkg::REG_ENABLES: st_next.rdata = {8'h00, st_reg.enables};
            evq_pkg::REG_TIMER_EN: st_next.rdata = {29'h0, st_reg.timer_en};
            evq_pkg::REG_TIMER0_IVL: st_next.rdata = {16'h0000, st_reg.interval[0]};
            evq_pkg::REG_TIMER1_IVL: st_next.rdata = {16'h0000, st_reg.interval[1]};
            evq_pkg::REG_TIMER2_IVL: st_next.rdata = {16'h0000, st_reg.interval[2]};
            evq_pkg::REG_SHARED: st_next.rdata = {24'h000000, st_reg.shared};
            evq_pkg::REG_CAPTURE: st_next.rdata = {24'h000000, st_reg.capture};
            evq_pkg::REG_STATUS: st_next.rdata = status;
            evq_pkg::REG_LINK_LO: st_next.rdata = st_reg.link[31:0];
            evq_pkg::REG_LINK_HI: st_next.rdata = st_reg.link[63:32];
            default: st_next.rdata = 32'h00000000;
         endcase
      end

      // Register write; timer enable changes leave queued requests alone
      if (wr_take) begin
         case (avs_address)
            evq_pkg::REG_CTRL: begin
               st_next.ctrl = 2'(merge({30'h0, st_reg.ctrl}, avs_writedata, avs_byteenable));
            end
            evq_pkg::REG_ENABLES: begin
               st_next.enables = 24'(merge({8'h00, st_reg.enables}, avs_writedata,
                                           avs_byteenable));
            end
            evq_pkg::REG_TIMER_EN: begin
               st_next.timer_en = 3'(merge({29'h0, st_reg.timer_en}, avs_writedata,
                                           avs_byteenable));
            end
            evq_pkg::REG_TIMER0_IVL: begin
               st_next.interval[0] = 16'(merge({16'h0000, st_reg.interval[0]}, avs_writedata,
                                               avs_byteenable));
            end
            evq_pkg::REG_TIMER1_IVL: begin
               st_next.interval[1] = 16'(merge({16'h0000, st_reg.interval[1]}, avs_writedata,
                                               avs_byteenable));
            end
            evq_pkg::REG_TIMER2_IVL: begin
               st_next.interval[2] = 16'(merge({16'h0000, st_reg.interval[2]}, avs_writedata,
                                               avs_byteenable));
            end
            evq_pkg::REG_SHARED: begin
               st_next.shared = 8'(merge({24'h000000, st_reg.shared}, avs_writedata,
                                         avs_byteenable));
            end
            evq_pkg::REG_STATUS: begin
               // Write one clears the lost flag; a new loss in the same cycle wins
               if (avs_byteenable[0] && avs_writedata[evq_pkg::ST_LOST_BIT]
                   && !(st_reg.masked && ((evt | st_reg.pending) != '0))) begin
                  st_next.lost = 1'b0;
               end
            end
            evq_pkg::REG_LINK_LO: begin
               st_next.link[31:0] = merge(st_reg.link[31:0], avs_writedata, avs_byteenable);
            end
            evq_pkg::REG_LINK_HI: begin
               st_next.link[63:32] = merge(st_reg.link[63:32], avs_writedata, avs_byteenable);
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= ST_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign avs_readdata = st_reg.rdata;
   assign avs_waitrequest = st_reg.waitreq;
   assign handler_start = st_reg.start;
   assign handler_event = st_reg.evt_out;
   assign main_suspend = st_reg.suspend;
   assign pulse_capture_flags = st_reg.capture;

endmodule

// ---- tb/evq_exec_model.sv ----
// Program executor model: one done pulse per handler start
`timescale 1ns/1ps
module evq_exec_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic handler_start,
   input wire logic [4:0] delay,
   output logic handler_done
);
   int cnt;
   // A long delay keeps a handler running while new events queue
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= 0;
         handler_done <= 1'b0;
      end else begin
         handler_done <= (cnt == 1);
         if (handler_start) cnt <= int'(delay) + 1;
         else if (cnt != 0) cnt <= cnt - 1;
      end
   end
endmodule

// ---- tb/evq_top_chk.sv ----
// Port checker for the event queue unit
`timescale 1ns/1ps
module evq_top_chk (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic [7:0] fast_inputs,
   input wire logic program_start,
   input wire logic handler_done,
   input wire logic handler_start,
   input wire logic [5:0] handler_event,
   input wire logic main_suspend,
   input wire logic [7:0] pulse_capture_flags
);
   logic run_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) run_reg <= 1'b0;
      else if (handler_start) run_reg <= 1'b1;
      else if (handler_done) run_reg <= 1'b0;
   end
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_ans;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   bus_answer_a: assert property (s_req |=> s_ans) else $error("bus answer late");
   capture_set_a: assert property (fast_inputs != $past(fast_inputs) |=>
      &(pulse_capture_flags | ~$past(fast_inputs) | $past(fast_inputs, 2)))
      else $error("capture flag missed");
   capture_clear_a: assert property (program_start && $stable(fast_inputs)
      |=> pulse_capture_flags == 8'h00) else $error("capture not cleared");
   suspend_a: assert property (handler_start |-> main_suspend)
      else $error("handler without suspend");
   dispatch_delay_a: assert property (handler_start |-> $past(main_suspend, 3))
      else $error("dispatch too early");
   event_hold_a: assert property (!handler_start |-> $stable(handler_event))
      else $error("event number moved");
   single_run_a: assert property (handler_start |-> !run_reg)
      else $error("handler preempted");
   main_resume_a: assert property ($fell(main_suspend) |-> !run_reg)
      else $error("resume while running");
endmodule
bind evq_top evq_top_chk evq_top_chk_i (.clk(clk), .arst_n(arst_n), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .fast_inputs(fast_inputs),
   .program_start(program_start), .handler_done(handler_done),
   .handler_start(handler_start), .handler_event(handler_event),
   .main_suspend(main_suspend), .pulse_capture_flags(pulse_capture_flags));

// ---- tb/evq_top_tb_top.sv ----
// Self-checking bench for the event queue unit
`timescale 1ns/1ps
module evq_top_tb_top;
   localparam int MS = 10;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] adr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat, r;
   logic wreq, hdone, hstart, susp;
   logic [7:0] fin = 8'h00, cev = 8'h00, sev = 8'h00, pev = 8'h00, cap, c, s, p;
   logic pstart = 1'b0;
   logic [5:0] hev;
   logic [4:0] dly = 5'h01;
   logic [5:0] seen[$];
   int ex[$];
   logic [63:0] m;
   int fail_count = 0;
   int comparisons = 0;
   int cyc = 0;
   int i, n, iv;
   always #10 clk = ~clk;
   evq_top #(.CYCLES_PER_MS(MS)) evq_top_i (.clk(clk), .arst_n(arst_n), .avs_address(adr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hF),
      .avs_readdata(rdat), .avs_waitrequest(wreq), .fast_inputs(fin), .counter_events(cev),
      .serial_events(sev), .pulse_done_events(pev), .program_start(pstart), .scan_end(1'b0),
      .handler_done(hdone), .handler_start(hstart), .handler_event(hev),
      .main_suspend(susp), .pulse_capture_flags(cap));
   evq_exec_model evq_exec_model_i (.clk(clk), .arst_n(arst_n), .handler_start(hstart),
      .delay(dly), .handler_done(hdone));
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Handler starts are logged; a hang ends the run
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (hstart === 1'b1) seen.push_back(hev);
      if (cyc > 20000) begin
         fail_count++;
         complete_run();
      end
   end
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= !w;
      do @(posedge clk); while (wreq !== 1'b0);
      r = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic drain(input int k);
      repeat (k) @(posedge clk);
      while (susp !== 1'b0) @(posedge clk);
   endtask
   function automatic logic [63:0] evset(logic [7:0] cc, logic [7:0] ss, logic [7:0] pp);
      logic [63:0] m;
      m = 64'h0;
      for (int b = 0; b < 8; b++) begin
         m[b < 6 ? 20 + b : 34 + b] = cc[b];
         m[30 + b] = ss[b];
         m[b < 2 ? 18 + b : 40 + b] = pp[b];
      end
      return m;
   endfunction
   initial begin
      void'($urandom(32'h286fcd05));
      i = $urandom % 5;
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      bus(1'b0, evq_pkg::REG_ENABLES, 32'h0);
      cmp("enables_rst", 32'h0, r);
      bus(1'b0, 4'hF, 32'h0);
      cmp("unmapped", 32'h0, r);
      bus(1'b1, evq_pkg::REG_CAPTURE, 32'hFF);
      bus(1'b0, evq_pkg::REG_CAPTURE, 32'h0);
      cmp("capture_ro", 32'h0, r);
      bus(1'b1, evq_pkg::REG_LINK_LO, 32'hFFFC7C80);
      bus(1'b1, evq_pkg::REG_LINK_HI, 32'hFFFFFFFF);
      bus(1'b1, evq_pkg::REG_ENABLES, 32'h00FFFFFF);
      fin <= 8'h01 << i;
      repeat (20) @(posedge clk);
      cmp("idle_no_global", 32'h0, 32'(susp));
      cmp("capture", 32'(8'h01 << i), 32'(cap));
      pstart <= 1'b1;
      @(posedge clk);
      pstart <= 1'b0;
      @(posedge clk);
      cmp("capture_start", 32'h0, 32'(cap));
      bus(1'b1, evq_pkg::REG_CTRL, 32'h3);
      fin <= 8'h00;
      repeat (2) @(posedge clk);
      fin <= 8'h80;
      drain(10);
      cmp("edge_count", 32'h2, 32'(seen.size()));
      cmp("fall_ev", 32'(10 + i), 32'(seen[0]));
      cmp("rise_ev", 32'h7, 32'(seen[1]));
      seen.delete();
      fin <= 8'hA0;
      drain(10);
      bus(1'b0, evq_pkg::REG_STATUS, 32'h0);
      cmp("unlinked", 32'h500, r);
      cmp("unlinked_n", 32'h0, 32'(seen.size()));
      $display("edge tests done");
      dly <= 5'h14;
      for (int k = 0; k < 3; k++) begin
         c = (k == 0) ? 8'h00 : $urandom;
         s = (k == 0) ? 8'h00 : $urandom;
         p = (k == 0) ? 8'hFF : $urandom;
         bus(1'b1, evq_pkg::REG_CTRL, (k == 2) ? 32'h1 : 32'h3);
         m = evset((k == 2) ? 8'h00 : c, s, p);
         ex.delete();
         for (int e = 0; e < 64; e++)
            if (m[e] && ex.size() < 8) ex.push_back(e);
         n = $countones(m);
         seen.delete();
         bus(1'b1, evq_pkg::REG_STATUS, 32'h80);
         cev <= c;
         sev <= s;
         pev <= p;
         @(posedge clk);
         cev <= 8'h00;
         sev <= 8'h00;
         pev <= 8'h00;
         drain(10);
         cmp("burst_n", 32'(ex.size()), 32'(seen.size()));
         foreach (ex[j]) cmp("burst_ev", 32'(ex[j]), 32'(seen[j]));
         bus(1'b0, evq_pkg::REG_STATUS, 32'h0);
         cmp("lost", {24'h0, n > 8, 7'h00}, {24'h0, r[7:0]});
         $display("burst round %0d done", k);
      end
      dly <= 5'h01;
      for (int t = 0; t < 4; t++) begin
         iv = 5 + t;
         bus(1'b1, 4'(evq_pkg::REG_TIMER0_IVL + t % 3), 32'(iv));
         seen.delete();
         bus(1'b1, evq_pkg::REG_TIMER_EN, 32'h1 << (t % 3));
         n = 0;
         while (seen.size() == 0 && n < 200) begin
            @(posedge clk);
            n++;
         end
         cmp("timer_ev", 32'(26 + t % 3), 32'(seen[0]));
         cmp("timer_gap", 32'h1, 32'(n >= MS * iv - 2 && n <= MS * iv + 12));
         bus(1'b1, evq_pkg::REG_TIMER_EN, 32'h0);
         drain(1);
      end
      $display("timer tests done");
      complete_run();
   end
endmodule
